/* rtl/uvfr_fault_response.sv */
// Output under-voltage fault threshold, response setting and retry controller
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module uvfr_fault_response
	import uvfr_pkg::*;
#(
	parameter logic [15:0] THR_RESET = UVFR_THR_RESET,
	parameter logic [7:0] ACT_RESET = UVFR_ACT_RESET,
	parameter logic [15:0] UNIT_RESET = UVFR_UNIT_RESET
)(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [7:0] wrCode,
	input wire logic [15:0] wrData,
	input wire logic [7:0] rdCode,
	output logic [15:0] rdData,
	output logic rdHit,
	input wire logic [15:0] voutMeas,
	input wire logic outputCmdOn,
	input wire logic biasOk,
	input wire logic otherFaultOff,
	input wire logic faultClear,
	output logic outputEnable,
	output logic uvFault,
	output logic faultLatched,
	output logic [2:0] attemptCount
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rstMeta_reg;
	logic rstSync_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	wire logic rstSync_n = rstSync_reg;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [UVFR_THR_W-1:0] thr_reg;
	logic [UVFR_ACT_W-1:0] act_reg;
	logic [UVFR_UNIT_W-1:0] unit_reg;
	logic [15:0] rdData_reg;
	logic rdHit_reg;

	wire logic wrThr = wrEn && (wrCode == UVFR_CMD_THRESHOLD);
	wire logic wrAct = wrEn && (wrCode == UVFR_CMD_ACTION);
	wire logic wrUnit = wrEn && (wrCode == UVFR_CMD_TIME_UNIT);

	wire logic rdIsThr = (rdCode == UVFR_CMD_THRESHOLD);
	wire logic rdIsAct = (rdCode == UVFR_CMD_ACTION);
	wire logic rdIsUnit = (rdCode == UVFR_CMD_TIME_UNIT);
	wire logic rdKnown = rdIsThr || rdIsAct || rdIsUnit;
	wire logic [15:0] rdMux = rdIsThr ? thr_reg :
		rdIsAct ? {8'h00, act_reg} :
		rdIsUnit ? unit_reg : 16'h0000;

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			thr_reg <= THR_RESET;
			act_reg <= ACT_RESET;
			unit_reg <= UNIT_RESET;
			rdData_reg <= 16'h0000;
			rdHit_reg <= 1'b0;
		end else begin
			if (wrThr) begin
				thr_reg <= wrData;
			end
			if (wrAct) begin
				act_reg <= wrData[7:0];
			end
			if (wrUnit) begin
				unit_reg <= wrData;
			end
			rdData_reg <= rdMux;
			rdHit_reg <= rdKnown;
		end
	end

	wire logic [1:0] respCode = act_reg[UVFR_RESP_HI:UVFR_RESP_LO];
	wire logic [2:0] retryField = act_reg[UVFR_RETRY_HI:UVFR_RETRY_LO];
	wire logic [2:0] dlyCode = act_reg[UVFR_DLY_HI:UVFR_DLY_LO];

	// ------------------------------------------------------------
	// Fault detection
	// ------------------------------------------------------------
	logic uv_reg;

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			uv_reg <= 1'b0;
		end else begin
			uv_reg <= voutMeas < thr_reg;
		end
	end

	// ------------------------------------------------------------
	// Delay timer
	// ------------------------------------------------------------
	uvfr_timer_if tif ();
	logic tStart_reg;

	assign tif.start = tStart_reg;
	assign tif.code = dlyCode;
	assign tif.unit = unit_reg;

	uvfr_delay_timer uvfr_delay_timer_inst (
		.core_clk(core_clk),
		.rstSync_n(rstSync_n),
		.tmr(tif)
	);

	// ------------------------------------------------------------
	// Response state machine
	// ------------------------------------------------------------
	uvfr_state_e state_reg;
	uvfr_state_e state_next;
	logic [2:0] tryCnt_reg;
	logic [2:0] tryCnt_next;
	logic tStart_next;
	logic outEn_reg;
	logic latched_reg;

	wire logic stopReq = !outputCmdOn || !biasOk || otherFaultOff;
	wire logic retriesLeft = (retryField == UVFR_RETRY_FOREVER) || (tryCnt_reg < retryField);
	wire logic noRetry = (retryField == UVFR_RETRY_NONE);
	wire uvfr_state_e shutState = noRetry ? ST_LATCH : ST_WAIT;

	always_comb begin
		state_next = state_reg;
		tryCnt_next = tryCnt_reg;
		tStart_next = 1'b0;
		if (stopReq) begin
			state_next = ST_OFF;
			tryCnt_next = 3'h0;
		end else begin
			unique case (state_reg)
				ST_OFF: begin
					state_next = ST_RUN;
				end
				ST_RUN: begin
					if (uv_reg) begin
						unique case (respCode)
							UVFR_RESP_IGNORE: state_next = ST_RUN;
							UVFR_RESP_DELAY: begin
								state_next = ST_DELAY;
								tStart_next = 1'b1;
							end
							UVFR_RESP_DISABLE: begin
								state_next = shutState;
								tStart_next = !noRetry;
							end
							UVFR_RESP_HOLD: state_next = ST_HOLD;
						endcase
					end
				end
				ST_DELAY: begin
					if (tif.expire) begin
						state_next = uv_reg ? shutState : ST_RUN;
						tStart_next = uv_reg && !noRetry;
					end
				end
				ST_WAIT: begin
					if (tif.expire) begin
						state_next = ST_TRY;
						tStart_next = 1'b1;
						tryCnt_next = tryCnt_reg + 3'h1;
					end
				end
				ST_TRY: begin
					if (tif.expire) begin
						if (!uv_reg) begin
							state_next = ST_RUN;
							tryCnt_next = 3'h0;
						end else if (retriesLeft) begin
							tStart_next = 1'b1;
							tryCnt_next = (retryField == UVFR_RETRY_FOREVER) ? tryCnt_reg : tryCnt_reg + 3'h1;
						end else begin
							state_next = ST_LATCH;
						end
					end
				end
				ST_LATCH: begin
					if (faultClear) begin
						state_next = ST_RUN;
						tryCnt_next = 3'h0;
					end
				end
				ST_HOLD: begin
					if (!uv_reg) begin
						state_next = ST_RUN;
					end
				end
			endcase
		end
	end

	wire logic outEn_next = (state_next == ST_RUN) || (state_next == ST_DELAY) || (state_next == ST_TRY);

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_reg <= ST_OFF;
			tryCnt_reg <= 3'h0;
			tStart_reg <= 1'b0;
			outEn_reg <= 1'b0;
			latched_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tryCnt_reg <= tryCnt_next;
			tStart_reg <= tStart_next;
			outEn_reg <= outEn_next;
			latched_reg <= (state_next == ST_LATCH);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdData = rdData_reg;
	assign rdHit = rdHit_reg;
	assign outputEnable = outEn_reg;
	assign uvFault = uv_reg;
	assign faultLatched = latched_reg;
	assign attemptCount = tryCnt_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_uv_compare: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		$past(rstSync_n) |-> uv_reg == ($past(voutMeas) < $past(thr_reg)))
		else $error("Under-voltage flag does not follow compare");

	a_ignore_keeps_on: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_RUN && respCode == UVFR_RESP_IGNORE && uv_reg && !stopReq) |=> outEn_reg)
		else $error("Output dropped while fault ignored");

	a_delay_keeps_on: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_RUN && respCode == UVFR_RESP_DELAY && uv_reg && !stopReq)
		|=> (state_reg == ST_DELAY && outEn_reg) ##1 tif.busy)
		else $error("Delay response did not keep running with timer");

	a_disable_now: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_RUN && respCode == UVFR_RESP_DISABLE && uv_reg) |=> !outEn_reg)
		else $error("Output not disabled at once");

	a_hold_resume: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_HOLD && !uv_reg && !stopReq) |=> outEn_reg && state_reg == ST_RUN)
		else $error("Output did not resume after fault went away");

	a_hold_stays_off: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		state_reg == ST_HOLD |-> !outEn_reg)
		else $error("Output on while fault holds it off");

	a_no_retry_latch: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_RUN && respCode == UVFR_RESP_DISABLE && uv_reg && !stopReq && noRetry)
		|=> state_reg == ST_LATCH [*2])
		else $error("No-retry setting did not latch off");

	a_retry_limit: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_TRY && retryField != UVFR_RETRY_FOREVER && !$changed(act_reg))
		|-> tryCnt_reg <= retryField)
		else $error("More restarts than programmed");

	a_latch_stays: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_LATCH && !faultClear && !stopReq) |=> state_reg == ST_LATCH && !outEn_reg)
		else $error("Latched fault left without clear");

	a_forever_retry: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_TRY && tif.expire && uv_reg && !stopReq && retryField == UVFR_RETRY_FOREVER)
		|=> state_reg == ST_TRY ##1 tif.busy)
		else $error("Continuous retry stopped");

	a_try_spacing: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(state_reg == ST_WAIT && tif.expire && !stopReq) |=> tStart_reg && state_reg == ST_TRY)
		else $error("Restart attempt not timed from delay");

	a_stop_wins: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		stopReq |=> !outEn_reg && state_reg == ST_OFF && tryCnt_reg == 3'h0)
		else $error("Output still on after stop request");

endmodule : uvfr_fault_response

/* rtl/uvfr_pkg.sv */
// Package with register map, field layout and timing constants for the output UV fault response block
package uvfr_pkg;

	// ------------------------------------------------------------
	// Register command codes
	// ------------------------------------------------------------
	localparam logic [7:0] UVFR_CMD_THRESHOLD = 8'h44;
	localparam logic [7:0] UVFR_CMD_ACTION = 8'h45;
	localparam logic [7:0] UVFR_CMD_TIME_UNIT = 8'hd2;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int UVFR_THR_W = 16;
	localparam int UVFR_VOUT_EXP = -12;
	localparam int UVFR_ACT_W = 8;
	localparam int UVFR_RESP_HI = 7;
	localparam int UVFR_RESP_LO = 6;
	localparam int UVFR_RETRY_HI = 5;
	localparam int UVFR_RETRY_LO = 3;
	localparam int UVFR_DLY_HI = 2;
	localparam int UVFR_DLY_LO = 0;
	localparam int UVFR_UNIT_W = 16;
	localparam int UVFR_CNT_W = 24;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] UVFR_RESP_IGNORE = 2'h0;
	localparam logic [1:0] UVFR_RESP_DELAY = 2'h1;
	localparam logic [1:0] UVFR_RESP_DISABLE = 2'h2;
	localparam logic [1:0] UVFR_RESP_HOLD = 2'h3;
	localparam logic [2:0] UVFR_RETRY_NONE = 3'h0;
	localparam logic [2:0] UVFR_RETRY_FOREVER = 3'h7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] UVFR_THR_RESET = 16'h0000;
	localparam logic [7:0] UVFR_ACT_RESET = 8'h00;
	localparam logic [15:0] UVFR_UNIT_RESET = 16'h0064;

	typedef enum logic [6:0] {
		ST_OFF = 7'h01,
		ST_RUN = 7'h02,
		ST_DELAY = 7'h04,
		ST_WAIT = 7'h08,
		ST_TRY = 7'h10,
		ST_LATCH = 7'h20,
		ST_HOLD = 7'h40
	} uvfr_state_e;

	// Delay code is a power of two of time units; a zero unit counts as one cycle
	function automatic logic [UVFR_CNT_W-1:0] uvfr_delay_cycles(input logic [2:0] code,
		input logic [UVFR_UNIT_W-1:0] unit);
		logic [UVFR_CNT_W-1:0] u;
		u = (unit == '0) ? UVFR_CNT_W'(1) : UVFR_CNT_W'(unit);
		return u << code;
	endfunction : uvfr_delay_cycles

endpackage : uvfr_pkg

/* rtl/uvfr_timer_if.sv */
// Interface carrying delay timer requests and expiry between the response controller and its timer
`timescale 1ns/1ps
interface uvfr_timer_if;
	logic start;
	logic [2:0] code;
	logic [15:0] unit;
	logic busy;
	logic expire;

	modport ctrl (output start, output code, output unit, input busy, input expire);
	modport tmr (input start, input code, input unit, output busy, output expire);
endinterface : uvfr_timer_if

/* rtl/uvfr_delay_timer.sv */
// Delay timer counting a power-of-two number of time units
`timescale 1ns/1ps
module uvfr_delay_timer
	import uvfr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstSync_n,
	uvfr_timer_if.tmr tmr
);

	logic [UVFR_CNT_W-1:0] remain_reg;
	logic busy_reg;
	logic expire_reg;
	wire logic lastTick = busy_reg && (remain_reg == UVFR_CNT_W'(1));

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			remain_reg <= '0;
			busy_reg <= 1'b0;
			expire_reg <= 1'b0;
		end else begin
			expire_reg <= lastTick && !tmr.start;
			if (tmr.start) begin
				remain_reg <= uvfr_delay_cycles(tmr.code, tmr.unit);
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				remain_reg <= remain_reg - UVFR_CNT_W'(1);
				busy_reg <= !lastTick;
			end
		end
	end

	assign tmr.busy = busy_reg;
	assign tmr.expire = expire_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_timer_load_len: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		tmr.start |=> remain_reg == uvfr_delay_cycles($past(tmr.code), $past(tmr.unit)))
		else $error("Delay timer loaded wrong length");

	a_timer_expire_end: assert property (@(posedge core_clk) disable iff (!rstSync_n)
		(lastTick && !tmr.start) |=> tmr.expire && !tmr.busy)
		else $error("Delay timer did not expire at end of count");

endmodule : uvfr_delay_timer

/* sim/uvfr_host_model.sv */
// Host model that writes and reads the fault response registers by command code
`timescale 1ns/1ps
module uvfr_host_model (
	input wire logic core_clk,
	output logic wrEn,
	output logic [7:0] wrCode,
	output logic [15:0] wrData,
	output logic [7:0] rdCode,
	input wire logic [15:0] rdData,
	input wire logic rdHit
);
	initial begin
		wrEn = 1'b0;
		wrCode = 8'h00;
		wrData = 16'h0000;
		rdCode = 8'h00;
	end

	// One-cycle strobe; idle data turned over so stale values never look valid
	task write_reg(input logic [7:0] c, input logic [15:0] d);
		@(posedge core_clk);
		wrEn <= 1'b1;
		wrCode <= c;
		wrData <= d;
		@(posedge core_clk);
		wrEn <= 1'b0;
		wrCode <= ~c;
		wrData <= ~d;
		#1;
	endtask : write_reg

	task read_reg(input logic [7:0] c, output logic [15:0] d, output logic hit);
		@(posedge core_clk);
		rdCode <= c;
		@(posedge core_clk);
		#1;
		d = rdData;
		hit = rdHit;
	endtask : read_reg
endmodule : uvfr_host_model

/* sim/output_uv_fault_response_tb.sv */
// Self-checking bench for the output under-voltage fault response block
`timescale 1ns/1ps
module output_uv_fault_response_tb;
	import uvfr_pkg::*;
	localparam logic [15:0] HI = 16'h6000;
	localparam logic [15:0] LO = 16'h4000;
	logic core_clk, rst_n, wrEn, rdHit, outputCmdOn, biasOk, otherFaultOff, faultClear;
	logic outputEnable, uvFault, faultLatched;
	logic [7:0] wrCode, rdCode;
	logic [15:0] wrData, rdData, voutMeas, d;
	logic [2:0] attemptCount;
	logic hit;
	int errorCnt = 0;
	int checksDone = 0;
	int cyc = 0;
	int n;

	uvfr_fault_response uvfr_fault_response_inst (.core_clk(core_clk), .rst_n(rst_n), .wrEn(wrEn),
		.wrCode(wrCode), .wrData(wrData), .rdCode(rdCode), .rdData(rdData), .rdHit(rdHit),
		.voutMeas(voutMeas), .outputCmdOn(outputCmdOn), .biasOk(biasOk), .otherFaultOff(otherFaultOff),
		.faultClear(faultClear), .outputEnable(outputEnable), .uvFault(uvFault),
		.faultLatched(faultLatched), .attemptCount(attemptCount));
	uvfr_host_model uvfr_host_model_inst (.core_clk(core_clk), .wrEn(wrEn), .wrCode(wrCode),
		.wrData(wrData), .rdCode(rdCode), .rdData(rdData), .rdHit(rdHit));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task reportAndStop;
		if (errorCnt == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : reportAndStop

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errorCnt++;
			reportAndStop;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errorCnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task setv(input logic [15:0] v);
		@(posedge core_clk);
		voutMeas <= v;
		#1;
	endtask : setv

	// Cycles until outputEnable reaches v, bounded
	task wait_oe(input logic v, input int lim, output int cnt);
		cnt = 0;
		while (outputEnable !== v && cnt < lim) begin
			@(posedge core_clk);
			#1;
			cnt++;
		end
	endtask : wait_oe

	task hold_chk(input logic v, input int k);
		int i;
		for (i = 0; i < k; i++) begin
			@(posedge core_clk);
			#1;
			chk(outputEnable, v);
		end
	endtask : hold_chk

	task clear_fault;
		setv(HI);
		@(posedge core_clk);
		faultClear <= 1'b1;
		@(posedge core_clk);
		faultClear <= 1'b0;
		#1;
		wait_oe(1'b1, 10, n);
		chk(outputEnable, 1'b1);
		chk(attemptCount, 3'h0);
	endtask : clear_fault

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_regs;
		uvfr_host_model_inst.read_reg(UVFR_CMD_THRESHOLD, d, hit);
		chk({hit, d}, {1'b1, 16'h0000});
		uvfr_host_model_inst.read_reg(UVFR_CMD_ACTION, d, hit);
		chk({hit, d}, {1'b1, 16'h0000});
		uvfr_host_model_inst.read_reg(UVFR_CMD_TIME_UNIT, d, hit);
		chk({hit, d}, {1'b1, 16'h0064});
		uvfr_host_model_inst.write_reg(8'h46, 16'h1234);
		uvfr_host_model_inst.read_reg(8'h46, d, hit);
		chk({hit, d}, {1'b0, 16'h0000});
		uvfr_host_model_inst.write_reg(UVFR_CMD_THRESHOLD, 16'h5abc);
		uvfr_host_model_inst.read_reg(UVFR_CMD_THRESHOLD, d, hit);
		chk(d, 16'h5abc);
		uvfr_host_model_inst.write_reg(UVFR_CMD_ACTION, 16'hff89);
		uvfr_host_model_inst.read_reg(UVFR_CMD_ACTION, d, hit);
		chk(d, 16'h0089);
		uvfr_host_model_inst.write_reg(UVFR_CMD_TIME_UNIT, 16'h0001);
		uvfr_host_model_inst.read_reg(UVFR_CMD_TIME_UNIT, d, hit);
		chk(d, 16'h0001);
		uvfr_host_model_inst.write_reg(UVFR_CMD_ACTION, 16'h0000);
		uvfr_host_model_inst.write_reg(UVFR_CMD_THRESHOLD, 16'h5000);
	endtask : t_regs

	task t_ignore;
		setv(16'h5000);
		repeat (3) @(posedge core_clk);
		#1;
		chk(uvFault, 1'b0);
		setv(16'h4fff);
		repeat (2) @(posedge core_clk);
		#1;
		chk(uvFault, 1'b1);
		hold_chk(1'b1, 20);
		setv(HI);
	endtask : t_ignore

	// Disable and retry over every delay code, retries 1 to 4
	task t_codes;
		int c;
		int r;
		int m;
		for (c = 0; c < 8; c++) begin
			r = (c % 4) + 1;
			m = 0;
			uvfr_host_model_inst.write_reg(UVFR_CMD_ACTION, {8'h00, 2'b10, 3'(r), 3'(c)});
			setv(LO);
			wait_oe(1'b0, 10, n);
			chk(n, 2);
			wait_oe(1'b1, 300, n);
			chk(n, (1 << c) + 2);
			chk(attemptCount, 3'h1);
			n = 0;
			while (faultLatched !== 1'b1 && n < 3000) begin
				@(posedge core_clk);
				#1;
				n++;
				if (attemptCount > m)
					m = attemptCount;
			end
			chk(m, r);
			hold_chk(1'b0, 8);
			clear_fault;
		end
	endtask : t_codes

	task t_noretry;
		uvfr_host_model_inst.write_reg(UVFR_CMD_ACTION, 16'h0080);
		setv(LO);
		hold_chk(1'b1, 1);
		hold_chk(1'b0, 40);
		chk({faultLatched, attemptCount}, 4'h8);
		clear_fault;
	endtask : t_noretry

	task t_hold;
		uvfr_host_model_inst.write_reg(UVFR_CMD_ACTION, 16'h00f9);
		setv(LO);
		wait_oe(1'b0, 10, n);
		chk(n, 2);
		hold_chk(1'b0, 10);
		setv(HI);
		wait_oe(1'b1, 10, n);
		chk(n, 2);
		chk(faultLatched, 1'b0);
	endtask : t_hold

	task t_delay;
		uvfr_host_model_inst.write_reg(UVFR_CMD_ACTION, 16'h004a);
		setv(LO);
		hold_chk(1'b1, 5);
		wait_oe(1'b0, 10, n);
		chk(outputEnable, 1'b0);
		setv(HI);
		wait_oe(1'b1, 30, n);
		chk(outputEnable, 1'b1);
		repeat (10) @(posedge core_clk);
		setv(LO);
		repeat (2) @(posedge core_clk);
		setv(HI);
		hold_chk(1'b1, 20);
	endtask : t_delay

	task t_forever;
		int s;
		int i;
		int rises;
		logic prev;
		logic latchSeen;
		uvfr_host_model_inst.write_reg(UVFR_CMD_ACTION, 16'h00b8);
		for (s = 0; s < 3; s++) begin
			rises = 0;
			latchSeen = 1'b0;
			setv(LO);
			// Restart attempts seen as delay timer start pulses
			prev = uvfr_fault_response_inst.tif.start;
			for (i = 0; i < 100; i++) begin
				@(posedge core_clk);
				#1;
				if (uvfr_fault_response_inst.tif.start === 1'b1 && prev === 1'b0)
					rises++;
				prev = uvfr_fault_response_inst.tif.start;
				latchSeen = latchSeen | faultLatched;
			end
			chk(rises >= 5, 1'b1);
			chk(latchSeen, 1'b0);
			chk(attemptCount, 3'h1);
			@(posedge core_clk);
			outputCmdOn <= (s != 0);
			biasOk <= (s != 1);
			otherFaultOff <= (s == 2);
			repeat (2) @(posedge core_clk);
			#1;
			chk({outputEnable, attemptCount}, 4'h0);
			hold_chk(1'b0, 10);
			@(posedge core_clk);
			voutMeas <= HI;
			outputCmdOn <= 1'b1;
			biasOk <= 1'b1;
			otherFaultOff <= 1'b0;
			#1;
			wait_oe(1'b1, 10, n);
			chk(outputEnable, 1'b1);
		end
	endtask : t_forever

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		voutMeas = HI;
		outputCmdOn = 1'b1;
		biasOk = 1'b1;
		otherFaultOff = 1'b0;
		faultClear = 1'b0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		chk(outputEnable, 1'b1);
		t_regs;
		t_ignore;
		t_codes;
		t_noretry;
		t_hold;
		t_delay;
		t_forever;
		reportAndStop;
	end
endmodule : output_uv_fault_response_tb
